/* File: pkg/xpt_cfg_map.vh */
// Constants for the crosspoint serial configuration host
`ifndef XPT_CFG_MAP_VH
`define XPT_CFG_MAP_VH

// ---------------------------------------------------------------
// Word layout
// ---------------------------------------------------------------
`define XPT_WORD_BITS      32
`define XPT_CODE_BITS      4
`define XPT_NUM_OUTPUTS    8
`define XPT_BIT_CNT_W      6

// ---------------------------------------------------------------
// Control codes
// ---------------------------------------------------------------
`define XPT_CODE_GROUND    4'h8
`define XPT_CODE_ENABLE    4'h9
`define XPT_CODE_DISABLE   4'hA
`define XPT_CODE_RESET     32'h0000_0000

// ---------------------------------------------------------------
// Timing, in nanoseconds and in SYS_CLK cycles
// ---------------------------------------------------------------
`define XPT_CLK_PERIOD_NS  8
`define XPT_HALF_NS        64
`define XPT_HALF_CYCLES    4'h8   // 64 ns at 8 ns a cycle, timer width
`define XPT_DIV_W          4

`endif

/* File: hw/strobe_timer.v */
// Half period timer for pin strobe timing
`timescale 1ns/1ps
module strobe_timer (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       start,
  output reg        done
);
`include "xpt_cfg_map.vh"

  reg [`XPT_DIV_W-1:0] count_reg;

  // Counts one half period after start, pulses done
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 4'h0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_reg <= `XPT_HALF_CYCLES;
      end else if (count_reg != 4'h0) begin
        count_reg <= count_reg - 4'h1;
        if (count_reg == 4'h1) begin
          done <= 1'b1;
        end
      end
    end
  end

endmodule // strobe_timer

/* File: hw/xpt_serial_host.v */
// Host that shifts configuration words into the crosspoint switch
`timescale 1ns/1ps
module xpt_serial_host (
  input  wire        SYS_CLK,
  input  wire        RST_N,
  input  wire        CMD_VALID,
  input  wire [31:0] CMD_WORD,
  input  wire        CMD_EDGE_MODE,
  input  wire        SERIAL_DATA_OUT_PIN,
  output reg         CMD_READY,
  output reg         CMD_DONE,
  output reg  [31:0] ECHO_WORD,
  output reg         SERIAL_DATA_IN_PIN,
  output reg         WRITE_STROBE,
  output reg         LATCH_STROBE,
  output reg         CHIP_ENABLE,
  output reg         CHIP_ENABLE_N
);
`include "xpt_cfg_map.vh"

  // -------------------------------------------------------------
  // States
  // -------------------------------------------------------------
  localparam ST_IDLE  = 3'd0;
  localparam ST_SETUP = 3'd1;
  localparam ST_HIGH  = 3'd2;
  localparam ST_LATLO = 3'd3;
  localparam ST_LATHI = 3'd4;
  localparam ST_DONE  = 3'd5;

  reg [2:0]                state_reg;
  reg [2:0]                state_next;
  reg [31:0]               word_reg;
  reg [31:0]               word_next;
  reg [31:0]               echo_reg;
  reg [31:0]               echo_next;
  reg [`XPT_BIT_CNT_W-1:0] bits_reg;
  reg [`XPT_BIT_CNT_W-1:0] bits_next;
  reg                      edge_reg;
  reg                      edge_next;
  reg                      sdi_next;
  reg                      wr_next;
  reg                      lat_next;
  reg                      start_next;
  reg                      start_reg;
  reg                      done_next;
  reg                      ready_next;
  reg [2:0]                sdo_sync;
  reg                      sdo_filt;
  wire                     half_done;

  // -------------------------------------------------------------
  // Pin input synchroniser, echo bit from daisy chain output
  // -------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sdo_sync <= 3'b000;
    end else begin
      sdo_sync <= {sdo_sync[1:0], SERIAL_DATA_OUT_PIN};
    end
  end

  // -------------------------------------------------------------
  // Echo bit filter, takes a change once two stages agree
  // -------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sdo_filt <= 1'b0;
    end else if (sdo_sync[2] == sdo_sync[1]) begin
      sdo_filt <= sdo_sync[2];
    end
  end

  strobe_timer u_timer (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .start (start_reg),
    .done  (half_done)
  );

  // -------------------------------------------------------------
  // Sequencer: 32 write pulses then a latch pulse
  // -------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    word_next  = word_reg;
    echo_next  = echo_reg;
    bits_next  = bits_reg;
    edge_next  = edge_reg;
    sdi_next   = SERIAL_DATA_IN_PIN;
    wr_next    = WRITE_STROBE;
    lat_next   = LATCH_STROBE;
    start_next = 1'b0;
    done_next  = 1'b0;
    ready_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        ready_next = 1'b1;
        lat_next   = 1'b1;
        if (CMD_VALID && CMD_READY) begin
          word_next  = CMD_WORD;
          edge_next  = CMD_EDGE_MODE;
          bits_next  = 6'd0;
          ready_next = 1'b0;
          lat_next   = 1'b1;            // No transfer while shifting
          state_next = ST_SETUP;
          sdi_next   = CMD_WORD[31];
          wr_next    = 1'b0;
          start_next = 1'b1;
        end
      end
      ST_SETUP: begin
        if (half_done) begin
          wr_next    = 1'b1;
          start_next = 1'b1;
          state_next = ST_HIGH;
          echo_next  = {echo_reg[30:0], sdo_filt};
        end
      end
      ST_HIGH: begin
        if (half_done) begin
          wr_next    = 1'b0;
          start_next = 1'b1;
          word_next  = {word_reg[30:0], 1'b0};
          bits_next  = bits_reg + 6'd1;
          if (bits_reg == 6'd31) begin
            state_next = ST_LATLO;
            lat_next   = 1'b0;
          end else begin
            sdi_next   = word_reg[30];
            state_next = ST_SETUP;
          end
        end
      end
      ST_LATLO: begin
        if (half_done) begin
          lat_next   = 1'b1;
          if (edge_reg) begin
            start_next = 1'b1;          // Edge mode: let the rise settle
            state_next = ST_LATHI;
          end else begin
            state_next = ST_DONE;       // Level mode moved word while low
          end
        end
      end
      ST_LATHI: begin
        if (half_done) begin
          lat_next   = 1'b1;            // Parked high in both modes
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // -------------------------------------------------------------
  // State registers
  // -------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      word_reg  <= `XPT_CODE_RESET;
      echo_reg  <= 32'h0000_0000;
      bits_reg  <= 6'd0;
      edge_reg  <= 1'b1;
      start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      word_reg  <= word_next;
      echo_reg  <= echo_next;
      bits_reg  <= bits_next;
      edge_reg  <= edge_next;
      start_reg <= start_next;
    end
  end

  // -------------------------------------------------------------
  // Pin and handshake outputs, all straight from flip-flops
  // -------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SERIAL_DATA_IN_PIN <= 1'b0;
      WRITE_STROBE       <= 1'b0;
      LATCH_STROBE       <= 1'b1;       // Parked high, no transfer
      CHIP_ENABLE        <= 1'b0;
      CHIP_ENABLE_N      <= 1'b1;
      CMD_READY          <= 1'b0;
      CMD_DONE           <= 1'b0;
      ECHO_WORD          <= 32'h0000_0000;
    end else begin
      SERIAL_DATA_IN_PIN <= sdi_next;
      WRITE_STROBE       <= wr_next;
      LATCH_STROBE       <= lat_next;
      CHIP_ENABLE        <= 1'b1;
      CHIP_ENABLE_N      <= 1'b0;
      CMD_READY          <= ready_next;
      CMD_DONE           <= done_next;
      if (done_next) begin
        ECHO_WORD <= echo_reg;
      end
    end
  end

endmodule // xpt_serial_host

/* File: testbench/xpt_serial_host_checker.sv */
// Timing checker for the crosspoint serial host pins
`timescale 1ns/1ps
module xpt_serial_host_checker (
  input wire SYS_CLK,
  input wire RST_N,
  input wire CMD_VALID,
  input wire CMD_READY,
  input wire CMD_DONE,
  input wire SERIAL_DATA_IN_PIN,
  input wire WRITE_STROBE,
  input wire LATCH_STROBE,
  input wire CHIP_ENABLE,
  input wire CHIP_ENABLE_N
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // ----
  // Pin rules
  // ----
  property p_ce; CMD_READY |-> CHIP_ENABLE && !CHIP_ENABLE_N; endproperty
  a_ce: assert property (p_ce) else $error("enables");
  property p_lhi; WRITE_STROBE |-> LATCH_STROBE; endproperty
  a_lhi: assert property (p_lhi) else $error("latch low");
  property p_dat;
    $rose(WRITE_STROBE) |-> $stable(SERIAL_DATA_IN_PIN);
  endproperty
  a_dat: assert property (p_dat) else $error("data moved");
  // Each strobe phase is ten clock cycles wide
  property p_wr;
    $rose(WRITE_STROBE) |=>
      WRITE_STROBE[*8] ##1 WRITE_STROBE ##1 !WRITE_STROBE;
  endproperty
  a_wr: assert property (p_wr) else $error("write width");
  property p_lt;
    $fell(LATCH_STROBE) |=>
      !LATCH_STROBE[*8] ##1 !LATCH_STROBE ##1 LATCH_STROBE;
  endproperty
  a_lt: assert property (p_lt) else $error("latch width");
  property p_dn; $rose(LATCH_STROBE) |-> ##[1:12] CMD_DONE; endproperty
  a_dn: assert property (p_dn) else $error("no done");
  property p_pl; CMD_DONE |=> !CMD_DONE && !WRITE_STROBE; endproperty
  a_pl: assert property (p_pl) else $error("done width");
  property p_tk; CMD_VALID && CMD_READY |=> !CMD_READY; endproperty
  a_tk: assert property (p_tk) else $error("still ready");
endmodule // xpt_serial_host_checker
bind xpt_serial_host xpt_serial_host_checker xpt_serial_host_checker_i (.*);

/* File: testbench/xpt_device_model.sv */
// Behavioural crosspoint device on the serial pins
`timescale 1ns/1ps
module xpt_device_model (
  input  wire        wr,
  input  wire        latch,
  input  wire        sdi,
  input  wire        ce,
  input  wire        ce_n,
  input  wire        edge_mode,
  output wire        sdo,
  output reg  [31:0] master_reg,
  output reg  [31:0] slave_reg,
  output reg  [7:0]  en_reg
);
  integer i;
  // Power-up: codes zero, outputs off
  initial begin
    master_reg = 32'h0000_0000;
    slave_reg = 32'h0000_0000;
    en_reg = 8'h00;
  end
  // Gated shift into bit zero
  always @(posedge wr) if (ce && !ce_n)
    master_reg <= {master_reg[30:0], sdi};
  assign sdo = master_reg[31];
  // Edge and low-level transfer
  always @(posedge latch) if (edge_mode) slave_reg <= master_reg;
  always @(latch or master_reg) if (!edge_mode && !latch)
    slave_reg <= master_reg;
  // Per-output enable decode only
  always @(slave_reg) for (i = 0; i < 8; i = i + 1)
    if (slave_reg[31-4*i -: 4] == 4'h9) en_reg[i] = 1'b1;
    else if (slave_reg[31-4*i -: 4] == 4'hA) en_reg[i] = 1'b0;
endmodule // xpt_device_model

/* File: testbench/xpt_serial_host_test.sv */
// Self-checking bench of the crosspoint serial host
`timescale 1ns/1ps
module xpt_serial_host_test;
  reg         clk, rst_n, valid, mode, hung;
  reg  [31:0] word, prev;
  reg  [7:0]  en_exp;
  wire        ready, done, sdi, wr, latch, ce, ce_n, sdo;
  wire [31:0] echo, slave;
  wire [7:0]  en;
  integer     n_fail, n_checks, seed, k;
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  xpt_serial_host xpt_serial_host_i (.SYS_CLK(clk), .RST_N(rst_n),
    .CMD_VALID(valid), .CMD_WORD(word), .CMD_EDGE_MODE(mode),
    .SERIAL_DATA_OUT_PIN(sdo), .CMD_READY(ready), .CMD_DONE(done),
    .ECHO_WORD(echo), .SERIAL_DATA_IN_PIN(sdi), .WRITE_STROBE(wr),
    .LATCH_STROBE(latch), .CHIP_ENABLE(ce), .CHIP_ENABLE_N(ce_n));
  xpt_device_model xpt_device_model_i (.wr(wr), .latch(latch), .sdi(sdi),
    .ce(ce), .ce_n(ce_n), .edge_mode(mode), .sdo(sdo), .master_reg(),
    .slave_reg(slave), .en_reg(en));
  // Expected enables after a word
  function [7:0] exp_en(input [7:0] old, input [31:0] w);
    integer i;
    begin
      exp_en = old;
      for (i = 0; i < 8; i = i + 1)
        if (w[31-4*i -: 4] == 4'h9) exp_en[i] = 1'b1;
        else if (w[31-4*i -: 4] == 4'hA) exp_en[i] = 1'b0;
    end
  endfunction
  task close_out;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk_word(input string nm, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_en(input string nm, input [7:0] e, input [7:0] g);
    chk_word(nm, {24'h00_0000, e}, {24'h00_0000, g});
  endtask
  // Send one word, wait for done, then compare
  task run(input [31:0] w, input m);
    integer t;
    begin
      if (!hung) begin
        word <= w;
        mode <= m;
        valid <= 1'b1;
        t = 0;
        do begin @(posedge clk); t = t + 1; end
        while (ready !== 1'b1 && t < 1000);
        valid <= 1'b0;
        do begin @(posedge clk); t = t + 1; end
        while (done !== 1'b1 && t < 2000);
        if (done !== 1'b1) begin
          n_fail = n_fail + 1;
          hung = 1'b1;
          $display("mismatch done exp 1 got %b", done);
        end else begin
          en_exp = exp_en(en_exp, w);
          chk_word("slave", w, slave);
          chk_word("echo", prev, echo);
          chk_en("enables", en_exp, en);
          prev = w;
        end
        $display("word %h mode %0d done", w, m);
      end
    end
  endtask
  // Main sequence
  initial begin
    seed = 40980;
    n_fail = 0;
    n_checks = 0;
    hung = 1'b0;
    prev = 32'h0000_0000;
    en_exp = 8'h00;
    rst_n = 1'b0;
    valid = 1'b0;
    word = 32'h0000_0000;
    mode = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_en("power-up", 8'h00, en);
    run(32'h9090_9099, 1'b1);
    run({prev[27:0], 4'hA}, 1'b1);
    run(32'hAAAA_AAAA, 1'b0);
    run(32'h0123_4567, 1'b0);
    for (k = 0; k < 6; k = k + 1) run($random(seed), k[0]);
    close_out;
  end
endmodule // xpt_serial_host_test
